// ---- design/ufl_map.svh ----
`ifndef UFL_MAP_SVH
`define UFL_MAP_SVH
// register indices; byte address is four times the index
`define UFL_IDX_HOLD     3'h0
`define UFL_IDX_DIV_HI   3'h1
`define UFL_IDX_FIFO     3'h2
`define UFL_IDX_LINE     3'h3
`define UFL_IDX_STATUS   3'h5
// line control value that opens the enhanced register
`define UFL_LCR_ENH_KEY  8'hbf
// fifo control fields
`define UFL_FCR_EN       0
`define UFL_FCR_RXCLR    1
`define UFL_FCR_TXCLR    2
`define UFL_FCR_DMA      3
`define UFL_FCR_TXT_LO   4
`define UFL_FCR_RXT_LO   6
// line control fields, then the enhanced register enable bit
`define UFL_LCR_PEN      3
`define UFL_LCR_EVEN     4
`define UFL_LCR_FORCE    5
`define UFL_LCR_BRK      6
`define UFL_LCR_DLAB     7
`define UFL_EFR_ENH      4
// reset values, then the shortest bit time
`define UFL_LCR_RST      8'h00
`define UFL_DIV_RST      16'h0010
`define UFL_MIN_BIT      16'h0002
`endif

// ---- design/ufl_pkg.sv ----
package ufl_pkg;
   typedef enum logic [5:0] {
      UFL_RX_IDLE  = 6'b000001,
      UFL_RX_START = 6'b000010,
      UFL_RX_DATA  = 6'b000100,
      UFL_RX_PAR   = 6'b001000,
      UFL_RX_STOP  = 6'b010000,
      UFL_RX_WAIT  = 6'b100000
   } ufl_rx_st_e;
   typedef enum logic [4:0] {
      UFL_TX_IDLE  = 5'b00001,
      UFL_TX_START = 5'b00010,
      UFL_TX_DATA  = 5'b00100,
      UFL_TX_PAR   = 5'b01000,
      UFL_TX_STOP  = 5'b10000
   } ufl_tx_st_e;
   typedef logic [7:0] ufl_byte_t;
endpackage

// ---- design/ufl_uart_fifo_line_core.sv ----
`timescale 1ns/1ps
`include "ufl_map.svh"
module ufl_uart_fifo_line_core
   import ufl_pkg::*;
#(
   parameter int DEPTH = 64
)(
   // clock and reset
   input  wire logic            clock,
   input  wire logic            rst_n,
   input  wire logic            clk_en,
   // apb slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [4:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   // serial line
   input  wire logic            rx,
   output logic                 tx,
   // dma signalling
   output logic                 dma_mode,
   output logic                 rx_trig_hit,
   output logic                 tx_trig_hit
);
   import ufl_pkg::*;
   localparam int AW = $clog2(DEPTH);

   // =====================================================
   // helpers
   function automatic ufl_byte_t len_mask(input logic [1:0] wl);
      len_mask = 8'hff >> (3'd3 - {1'b0, wl});
   endfunction
   function automatic logic par_bit(input ufl_byte_t d, input ufl_byte_t lc);
      if (lc[`UFL_LCR_FORCE])
         par_bit = ~lc[`UFL_LCR_EVEN];
      else
         par_bit = lc[`UFL_LCR_EVEN] ? ^d : ~^d;
   endfunction

   // =====================================================
   // register state
   ufl_byte_t        line_control_r;
   logic [15:0]      divisor_r;
   logic             enh_en_r;
   logic             fifo_en_r;
   logic             dma_mode_r;
   logic [1:0]       tx_trig_r;
   logic [1:0]       rx_trig_r;
   logic             overrun_r;
   logic [31:0]      prdata_r;

   logic             acc;
   logic             wr_acc;
   logic             rd_acc;
   logic [2:0]       idx;
   logic             dlab;
   logic             enh_key;
   logic             hit;
   logic             wr_fifo_ctl;
   logic             rx_clr;
   logic             tx_clr;
   logic             rx_pop;
   logic             tx_push;
   logic             stat_rd;

   assign acc     = psel & penable & clk_en;
   assign wr_acc  = acc & pwrite;
   assign rd_acc  = acc & ~pwrite;
   assign idx     = paddr[4:2];
   assign dlab    = line_control_r[`UFL_LCR_DLAB];
   assign enh_key = (line_control_r == `UFL_LCR_ENH_KEY);
   assign hit     = (idx == `UFL_IDX_HOLD) || (idx == `UFL_IDX_LINE) || (idx == `UFL_IDX_STATUS)
                 || (idx == `UFL_IDX_FIFO) || (dlab && idx == `UFL_IDX_DIV_HI);
   assign wr_fifo_ctl = wr_acc && idx == `UFL_IDX_FIFO && !dlab;
   assign rx_clr  = wr_fifo_ctl && (pwdata[`UFL_FCR_RXCLR] || pwdata[`UFL_FCR_EN] != fifo_en_r);
   assign tx_clr  = wr_fifo_ctl && (pwdata[`UFL_FCR_TXCLR] || pwdata[`UFL_FCR_EN] != fifo_en_r);
   assign rx_pop  = rd_acc && idx == `UFL_IDX_HOLD && !dlab;
   assign tx_push = wr_acc && idx == `UFL_IDX_HOLD && !dlab;
   assign stat_rd = rd_acc && idx == `UFL_IDX_STATUS;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign prdata  = prdata_r;
   assign dma_mode = dma_mode_r;

   // =====================================================
   // receive fifo
   logic [10:0]      rx_mem [DEPTH];
   logic [AW-1:0]    rx_wp_r;
   logic [AW-1:0]    rx_rp_r;
   logic [AW:0]      rx_cnt_r;
   logic [AW:0]      rx_err_cnt_r;
   logic             rx_done;
   logic [10:0]      rx_word;
   logic             rx_full;
   logic             rx_store;
   logic             rx_take;
   logic [10:0]      rx_head;
   logic [AW-1:0]    rx_wa;
   logic [AW-1:0]    rx_ra;

   assign rx_full  = fifo_en_r ? (rx_cnt_r == (AW+1)'(DEPTH)) : (rx_cnt_r != '0);
   assign rx_store = rx_done & ~rx_full & ~rx_clr;
   assign rx_take  = rx_pop & (rx_cnt_r != '0) & ~rx_clr;
   assign rx_wa    = fifo_en_r ? rx_wp_r : '0;
   assign rx_ra    = fifo_en_r ? rx_rp_r : '0;
   assign rx_head  = rx_mem[rx_ra];

   always_ff @(posedge clock)
   begin
      if (clk_en && rx_store)
         rx_mem[rx_wa] <= rx_word;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_wp_r      <= '0;
         rx_rp_r      <= '0;
         rx_cnt_r     <= '0;
         rx_err_cnt_r <= '0;
      end
      else if (clk_en)
      begin
         if (rx_clr)
         begin
            rx_wp_r      <= '0;
            rx_rp_r      <= '0;
            rx_cnt_r     <= '0;
            rx_err_cnt_r <= '0;
         end
         else
         begin
            if (rx_store)
               rx_wp_r <= rx_wp_r + 1'b1;
            if (rx_take)
               rx_rp_r <= rx_rp_r + 1'b1;
            rx_cnt_r <= rx_cnt_r + (AW+1)'(rx_store) - (AW+1)'(rx_take);
            rx_err_cnt_r <= rx_err_cnt_r + (AW+1)'(rx_store & (|rx_word[10:8]))
                          - (AW+1)'(rx_take & (|rx_head[10:8]));
         end
      end
   end

   // =====================================================
   // transmit fifo
   ufl_byte_t        tx_mem [DEPTH];
   logic [AW-1:0]    tx_wp_r;
   logic [AW-1:0]    tx_rp_r;
   logic [AW:0]      tx_cnt_r;
   logic             tx_full;
   logic             tx_store;
   logic             tx_load;
   logic [AW-1:0]    tx_wa;
   logic [AW-1:0]    tx_ra;

   assign tx_full  = fifo_en_r ? (tx_cnt_r == (AW+1)'(DEPTH)) : (tx_cnt_r != '0);
   assign tx_store = tx_push & ~tx_full & ~tx_clr;
   assign tx_wa    = fifo_en_r ? tx_wp_r : '0;
   assign tx_ra    = fifo_en_r ? tx_rp_r : '0;

   always_ff @(posedge clock)
   begin
      if (clk_en && tx_store)
         tx_mem[tx_wa] <= pwdata[7:0];
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_wp_r  <= '0;
         tx_rp_r  <= '0;
         tx_cnt_r <= '0;
      end
      else if (clk_en)
      begin
         if (tx_clr)
         begin
            tx_wp_r  <= '0;
            tx_rp_r  <= '0;
            tx_cnt_r <= '0;
         end
         else
         begin
            if (tx_store)
               tx_wp_r <= tx_wp_r + 1'b1;
            if (tx_load)
               tx_rp_r <= tx_rp_r + 1'b1;
            tx_cnt_r <= tx_cnt_r + (AW+1)'(tx_store) - (AW+1)'(tx_load);
         end
      end
   end

   // =====================================================
   // trigger levels
   logic [AW:0]      rx_lvl;
   logic [AW:0]      tx_lvl;
   always_comb
   begin
      case (rx_trig_r)
         2'b00:   rx_lvl = (AW+1)'(1);
         2'b01:   rx_lvl = (AW+1)'(4);
         2'b10:   rx_lvl = (AW+1)'(56);
         default: rx_lvl = (AW+1)'(60);
      endcase
      case (tx_trig_r)
         2'b00:   tx_lvl = (AW+1)'(8);
         2'b01:   tx_lvl = (AW+1)'(16);
         2'b10:   tx_lvl = (AW+1)'(32);
         default: tx_lvl = (AW+1)'(56);
      endcase
   end
   assign rx_trig_hit = rx_cnt_r >= rx_lvl;
   assign tx_trig_hit = ((AW+1)'(DEPTH) - tx_cnt_r) >= tx_lvl;

   // =====================================================
   // register writes
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_control_r <= `UFL_LCR_RST;
         divisor_r      <= `UFL_DIV_RST;
         enh_en_r       <= 1'b0;
         fifo_en_r      <= 1'b0;
         dma_mode_r     <= 1'b0;
         tx_trig_r      <= 2'b00;
         rx_trig_r      <= 2'b00;
      end
      else if (wr_acc)
      begin
         if (idx == `UFL_IDX_LINE)
            line_control_r <= pwdata[7:0];
         if (dlab && idx == `UFL_IDX_HOLD)
            divisor_r[7:0] <= pwdata[7:0];
         if (dlab && idx == `UFL_IDX_DIV_HI)
            divisor_r[15:8] <= pwdata[7:0];
         if (enh_key && idx == `UFL_IDX_FIFO)
            enh_en_r <= pwdata[`UFL_EFR_ENH];
         if (wr_fifo_ctl)
         begin
            fifo_en_r  <= pwdata[`UFL_FCR_EN];
            dma_mode_r <= pwdata[`UFL_FCR_DMA];
            rx_trig_r  <= pwdata[`UFL_FCR_RXT_LO +: 2];
            if (enh_en_r)
               tx_trig_r <= pwdata[`UFL_FCR_TXT_LO +: 2];
         end
      end
   end

   // =====================================================
   // register reads, captured in the setup phase
   ufl_byte_t        status;
   logic             tx_busy;
   assign status = {(rx_err_cnt_r != '0),
                    (tx_cnt_r == '0) & ~tx_busy, (tx_cnt_r == '0),
                    (rx_cnt_r != '0) ? rx_head[10:8] : 3'b000,
                    overrun_r, (rx_cnt_r != '0)};

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         prdata_r <= '0;
      else if (clk_en && psel && !penable && !pwrite)
      begin
         prdata_r <= '0;
         case (idx)
            `UFL_IDX_HOLD:   prdata_r[7:0] <= dlab ? divisor_r[7:0] : rx_head[7:0];
            `UFL_IDX_DIV_HI: prdata_r[7:0] <= dlab ? divisor_r[15:8] : 8'h00;
            `UFL_IDX_FIFO:   prdata_r[7:0] <= enh_key ? {3'b000, enh_en_r, 4'h0} : 8'h00;
            `UFL_IDX_LINE:   prdata_r[7:0] <= line_control_r;
            `UFL_IDX_STATUS: prdata_r[7:0] <= status;
            default:         prdata_r[7:0] <= 8'h00;
         endcase
      end
   end

   // overrun: a store lost in the same cycle as a status read still shows next time
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         overrun_r <= 1'b0;
      else if (clk_en)
      begin
         if (rx_done && rx_full)
            overrun_r <= 1'b1;
         else if (stat_rd)
            overrun_r <= 1'b0;
      end
   end

   // =====================================================
   // bit timing: bit length shared by both directions, stop length used by the transmitter only
   logic [15:0]      bit_len;
   logic [2:0]       stop_halves;
   assign bit_len = (divisor_r < `UFL_MIN_BIT) ? `UFL_MIN_BIT : divisor_r;
   assign stop_halves = !line_control_r[2] ? 3'd2 : (line_control_r[1:0] == 2'b00) ? 3'd3 : 3'd4;

   // =====================================================
   // receiver
   ufl_rx_st_e       rx_st_r;
   logic [15:0]      rx_tmr_r;
   logic [2:0]       rx_bit_r;
   ufl_byte_t        rx_sh_r;
   logic             rx_perr_r;
   logic             rx_any1_r;
   ufl_byte_t        rx_data;
   logic             rx_tick;

   assign rx_tick = (rx_tmr_r == '0);
   assign rx_data = (rx_sh_r >> (3'd3 - {1'b0, line_control_r[1:0]})) & len_mask(line_control_r[1:0]);
   assign rx_done = (rx_st_r == UFL_RX_STOP) & rx_tick;
   // break stores a zero byte; no stop bit means a framing fault
   assign rx_word = {~rx_any1_r & ~rx, ~rx, rx_perr_r, rx_any1_r ? rx_data : 8'h00};

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_st_r   <= UFL_RX_IDLE;
         rx_tmr_r  <= '0;
         rx_bit_r  <= '0;
         rx_sh_r   <= '0;
         rx_perr_r <= 1'b0;
         rx_any1_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!rx_tick)
            rx_tmr_r <= rx_tmr_r - 1'b1;
         case (rx_st_r)
            UFL_RX_IDLE:
               if (!rx)
               begin
                  rx_tmr_r  <= (bit_len >> 1) - 1'b1;
                  rx_perr_r <= 1'b0;
                  rx_any1_r <= 1'b0;
                  rx_st_r   <= UFL_RX_START;
               end
            UFL_RX_START:
               if (rx_tick)
               begin
                  // a start bit gone high at mid-bit was noise
                  rx_tmr_r <= bit_len - 1'b1;
                  rx_bit_r <= '0;
                  rx_st_r  <= rx ? UFL_RX_IDLE : UFL_RX_DATA;
               end
            UFL_RX_DATA:
               if (rx_tick)
               begin
                  rx_tmr_r  <= bit_len - 1'b1;
                  rx_sh_r   <= {rx, rx_sh_r[7:1]};
                  rx_any1_r <= rx_any1_r | rx;
                  rx_bit_r  <= rx_bit_r + 1'b1;
                  if (rx_bit_r == {1'b1, line_control_r[1:0]})
                     rx_st_r <= line_control_r[`UFL_LCR_PEN] ? UFL_RX_PAR : UFL_RX_STOP;
               end
            UFL_RX_PAR:
               if (rx_tick)
               begin
                  rx_tmr_r  <= bit_len - 1'b1;
                  rx_any1_r <= rx_any1_r | rx;
                  rx_perr_r <= rx != par_bit(rx_data, line_control_r);
                  rx_st_r   <= UFL_RX_STOP;
               end
            UFL_RX_STOP:
               if (rx_tick)
                  rx_st_r <= rx ? UFL_RX_IDLE : UFL_RX_WAIT;
            UFL_RX_WAIT:
               if (rx)
                  rx_st_r <= UFL_RX_IDLE;
            default:
               rx_st_r <= UFL_RX_IDLE;
         endcase
      end
   end

   // =====================================================
   // transmitter
   ufl_tx_st_e       tx_st_r;
   logic [15:0]      tx_tmr_r;
   logic [2:0]       tx_bit_r;
   ufl_byte_t        tx_sh_r;
   logic             tx_par_r;
   logic             tx_line_r;
   logic             tx_tick;

   assign tx_tick = (tx_tmr_r == '0);
   assign tx_load = (tx_st_r == UFL_TX_IDLE) & (tx_cnt_r != '0) & ~tx_clr;
   assign tx_busy = (tx_st_r != UFL_TX_IDLE);
   assign tx      = tx_line_r & ~line_control_r[`UFL_LCR_BRK];

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_st_r   <= UFL_TX_IDLE;
         tx_tmr_r  <= '0;
         tx_bit_r  <= '0;
         tx_sh_r   <= '0;
         tx_par_r  <= 1'b0;
         tx_line_r <= 1'b1;
      end
      else if (clk_en)
      begin
         if (!tx_tick)
            tx_tmr_r <= tx_tmr_r - 1'b1;
         case (tx_st_r)
            UFL_TX_IDLE:
               if (tx_load)
               begin
                  tx_sh_r   <= tx_mem[tx_ra] & len_mask(line_control_r[1:0]);
                  tx_par_r  <= par_bit(tx_mem[tx_ra] & len_mask(line_control_r[1:0]), line_control_r);
                  tx_tmr_r  <= bit_len - 1'b1;
                  tx_line_r <= 1'b0;
                  tx_st_r   <= UFL_TX_START;
               end
            UFL_TX_START:
               if (tx_tick)
               begin
                  tx_tmr_r  <= bit_len - 1'b1;
                  tx_bit_r  <= '0;
                  tx_line_r <= tx_sh_r[0];
                  tx_sh_r   <= tx_sh_r >> 1;
                  tx_st_r   <= UFL_TX_DATA;
               end
            UFL_TX_DATA:
               if (tx_tick)
               begin
                  tx_tmr_r <= bit_len - 1'b1;
                  tx_bit_r <= tx_bit_r + 1'b1;
                  if (tx_bit_r == {1'b1, line_control_r[1:0]})
                  begin
                     tx_line_r <= line_control_r[`UFL_LCR_PEN] ? tx_par_r : 1'b1;
                     if (!line_control_r[`UFL_LCR_PEN])
                        tx_tmr_r <= 16'((32'(bit_len) * 32'(stop_halves)) >> 1) - 1'b1;
                     tx_st_r <= line_control_r[`UFL_LCR_PEN] ? UFL_TX_PAR : UFL_TX_STOP;
                  end
                  else
                  begin
                     tx_line_r <= tx_sh_r[0];
                     tx_sh_r   <= tx_sh_r >> 1;
                  end
               end
            UFL_TX_PAR:
               if (tx_tick)
               begin
                  tx_tmr_r  <= 16'((32'(bit_len) * 32'(stop_halves)) >> 1) - 1'b1;
                  tx_line_r <= 1'b1;
                  tx_st_r   <= UFL_TX_STOP;
               end
            UFL_TX_STOP:
               if (tx_tick)
                  tx_st_r <= UFL_TX_IDLE;
            default:
               tx_st_r <= UFL_TX_IDLE;
         endcase
      end
   end
endmodule

// ---- testbench/ufl_core_sva.sv ----
`timescale 1ns/1ps
module ufl_core_sva
   import ufl_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        clk_en,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [4:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // line and dma
   input wire logic        rx,
   input wire logic        tx,
   input wire logic        dma_mode,
   input wire logic        rx_trig_hit,
   input wire logic        tx_trig_hit
);
   import ufl_pkg::*;
   logic [7:0] lcr_r;
   logic       acc;
   logic       fifo_control;
   assign acc = psel && penable && clk_en;
   assign fifo_control = !lcr_r[7] && paddr[4:2] == 3'h2;
   // shadow of line control: tells fifo control writes from the enhanced register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         lcr_r <= 8'h00;
      else if (acc && pwrite && paddr[4:2] == 3'h3)
         lcr_r <= pwdata[7:0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   unmapped_err_a: assert property (acc && paddr[4:2] inside {3'h4, 3'h6, 3'h7} |-> pslverr)
      else $error("unmapped access without error");
   div_hi_err_a: assert property (acc && paddr[4:2] == 3'h1 && !lcr_r[7] |-> pslverr)
      else $error("divisor high reachable while latch closed");
   fcr_read_a: assert property (psel && !penable && !pwrite && clk_en && fifo_control |=> prdata == 32'h0)
      else $error("fifo control readable");
   lcr_read_a: assert property (psel && !penable && !pwrite && clk_en && paddr[4:2] == 3'h3
      |=> prdata[7:0] == lcr_r) else $error("line control readback wrong");
   dma_sel_a: assert property (acc && pwrite && fifo_control |=> dma_mode == $past(pwdata[3]))
      else $error("dma mode not following write");
   rx_clear_a: assert property (acc && pwrite && fifo_control && pwdata[1] |-> ##[1:2] !rx_trig_hit)
      else $error("receive fifo not cleared");
   tx_clear_a: assert property (acc && pwrite && fifo_control && pwdata[2] |-> ##[1:2] tx_trig_hit)
      else $error("transmit fifo not cleared");
   brk_low_a: assert property (acc && pwrite && paddr[4:2] == 3'h3 && pwdata[6] |-> ##[1:2] !tx)
      else $error("break not driven");
   brk_hold_a: assert property (lcr_r[6] && $past(lcr_r[6]) |-> !tx)
      else $error("line released during break");
   start_bit_a: assert property ($fell(tx) |=> !tx)
      else $error("start bit too short");
endmodule

bind ufl_uart_fifo_line_core ufl_core_sva u_sva (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx(rx), .tx(tx), .dma_mode(dma_mode), .rx_trig_hit(rx_trig_hit), .tx_trig_hit(tx_trig_hit));

// ---- testbench/ufl_remote.sv ----
`timescale 1ns/1ps
module ufl_remote
   import ufl_pkg::*;
#(
   parameter int BIT = 4
)(
   // clock
   input  wire logic clock,
   // serial line seen from the far end
   input  wire logic tx,
   output logic      rx
);
   import ufl_pkg::*;
   initial rx = 1'b1;
   task automatic put(input logic v);
      rx <= v;
      repeat (BIT) @(posedge clock);
   endtask
   // brk holds the line low over the whole frame, stop bit included
   task automatic send(input ufl_byte_t d, input int n, input bit pen, input bit pb, input bit brk);
      @(posedge clock);
      put(1'b0);
      for (int i = 0; i < n; i++)
         put(!brk && d[i]);
      if (pen)
         put(!brk && pb);
      put(!brk);
      if (brk)
         put(1'b1);
   endtask
   // samples mid-bit; the caller starts it before the frame begins
   task automatic capture(input int n, input bit pen, output ufl_byte_t d, output logic p);
      d = 8'h00;
      p = 1'b0;
      @(posedge clock);
      while (tx !== 1'b0) @(posedge clock);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < n; i++)
      begin
         repeat (BIT) @(posedge clock);
         d[i] = tx;
      end
      if (pen)
      begin
         repeat (BIT) @(posedge clock);
         p = tx;
      end
   endtask
endmodule

// ---- testbench/ufl_uart_fifo_line_core_test.sv ----
`timescale 1ns/1ps
module ufl_uart_fifo_line_core_test;
   import ufl_pkg::*;
   localparam int BIT = 4;
   logic        clock;
   logic        rst_n;
   logic        clk_en;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [4:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx;
   logic        tx;
   logic        dma_mode;
   logic        rx_trig_hit;
   logic        tx_trig_hit;
   int          n_errors;
   int          comparisons;
   int          cycles;
   ufl_byte_t   rd_v;
   logic        rd_e;
   ufl_uart_fifo_line_core dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx(rx), .tx(tx), .dma_mode(dma_mode), .rx_trig_hit(rx_trig_hit), .tx_trig_hit(tx_trig_hit));
   ufl_remote #(.BIT(BIT)) rm (.clock(clock), .tx(tx), .rx(rx));
   always #2 clock = ~clock;
   // ==========================================
   // checking and bus tasks
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      chk({7'h0, got}, {7'h0, exp});
   endtask
   // entered just after a rising edge; leaves one idle cycle so strobes never collide
   task automatic apb(input logic w, input logic [2:0] idx, input ufl_byte_t d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd_v = prdata[7:0];
      rd_e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [2:0] idx, input ufl_byte_t d);
      apb(1'b1, idx, d);
   endtask
   task automatic rd(input logic [2:0] idx);
      apb(1'b0, idx, 8'h00);
   endtask
   // ==========================================
   // scenarios
   task automatic t_regs();
      chk_b(tx, 1'b1);
      chk_b(tx_trig_hit, 1'b1);
      chk_b(rx_trig_hit, 1'b0);
      chk_b(dma_mode, 1'b0);
      rd(3'h3);
      chk(rd_v, 8'h00);
      rd(3'h5);
      chk(rd_v, 8'h60);
      rd(3'h2);
      chk(rd_v, 8'h00);
      rd(3'h4);
      chk_b(rd_e, 1'b1);
      rd(3'h1);
      chk_b(rd_e, 1'b1);
      wr(3'h3, 8'h80);
      wr(3'h0, 8'(BIT));
      wr(3'h1, 8'h00);
      rd(3'h1);
      chk_b(rd_e, 1'b0);
      rd(3'h0);
      chk(rd_v, 8'(BIT));
      wr(3'h3, 8'h03);
      chk_b(pready, 1'b1);
      // a write made while the clock enable is low must leave line control alone
      clk_en <= 1'b0;
      wr(3'h3, 8'h1f);
      clk_en <= 1'b1;
      rd(3'h3);
      chk(rd_v, 8'h03);
      $display("t_regs done");
   endtask
   task automatic t_tx();
      ufl_byte_t  d;
      logic       p;
      logic [7:0] cfg [4] = '{8'h1b, 8'h0b, 8'h2b, 8'h3b};
      logic       par [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      for (int k = 0; k < 8; k++)
      begin
         wr(3'h3, (k < 4) ? 8'(k) : cfg[k - 4]);
         fork
            wr(3'h0, 8'hb7);
            rm.capture((k < 4) ? 5 + k : 8, k >= 4, d, p);
         join
         if (k < 4)
            chk(d, 8'hb7 & (8'hff >> (3 - k)));
         else
            chk_b(p, par[k - 4]);
         if (k == 7)
         begin
            rd(3'h5);
            chk(rd_v & 8'h60, 8'h20);
         end
         repeat (3 * BIT) @(posedge clock);
      end
      // two stop bits keep the shifter busy one bit time past a single stop
      wr(3'h3, 8'h07);
      fork
         wr(3'h0, 8'h5a);
         rm.capture(8, 1'b0, d, p);
      join
      chk(d, 8'h5a);
      repeat (5) @(posedge clock);
      rd(3'h5);
      chk(rd_v & 8'h60, 8'h20);
      repeat (4) @(posedge clock);
      rd(3'h5);
      chk(rd_v & 8'h60, 8'h60);
      wr(3'h3, 8'h43);
      @(posedge clock);
      chk_b(tx, 1'b0);
      wr(3'h3, 8'h03);
      @(posedge clock);
      chk_b(tx, 1'b1);
      $display("t_tx done");
   endtask
   task automatic t_rx_single();
      rm.send(8'h3c, 8, 1'b0, 1'b0, 1'b0);
      rm.send(8'hc3, 8, 1'b0, 1'b0, 1'b0);
      rd(3'h5);
      chk(rd_v, 8'h63);
      rd(3'h5);
      chk(rd_v, 8'h61);
      rd(3'h0);
      chk(rd_v, 8'h3c);
      rd(3'h5);
      chk(rd_v, 8'h60);
      $display("t_rx_single done");
   endtask
   task automatic t_rx_fifo();
      wr(3'h2, 8'h01);
      wr(3'h3, 8'h0b);
      rm.send(8'h11, 8, 1'b1, 1'b0, 1'b0);
      rm.send(8'h22, 8, 1'b1, 1'b1, 1'b0);
      for (int k = 0; k < 2; k++)
      begin
         rd(3'h5);
         chk(rd_v, 8'he5);
      end
      rd(3'h0);
      chk(rd_v, 8'h11);
      rd(3'h5);
      chk(rd_v, 8'h61);
      rd(3'h0);
      chk(rd_v, 8'h22);
      wr(3'h3, 8'h03);
      rm.send(8'h00, 8, 1'b0, 1'b0, 1'b1);
      rd(3'h5);
      chk(rd_v, 8'hf9);
      rd(3'h0);
      chk(rd_v, 8'h00);
      rm.send(8'h5a, 8, 1'b0, 1'b0, 1'b0);
      wr(3'h2, 8'h03);
      rd(3'h5);
      chk(rd_v, 8'h60);
      $display("t_rx_fifo done");
   endtask
   task automatic t_trig();
      wr(3'h2, 8'h49);
      chk_b(dma_mode, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         chk_b(rx_trig_hit, 1'b0);
         rm.send(8'(k), 8, 1'b0, 1'b0, 1'b0);
      end
      chk_b(rx_trig_hit, 1'b1);
      // twelve quick writes outrun the shifter, leaving about 53 spaces
      for (int r = 0; r < 2; r++)
      begin
         wr(3'h2, 8'h35);
         for (int k = 0; k < 12; k++)
            wr(3'h0, 8'(k));
         @(posedge clock);
         chk_b(tx_trig_hit, r == 0);
         wr(3'h3, 8'hbf);
         wr(3'h2, 8'h10);
         wr(3'h3, 8'h03);
      end
      wr(3'h2, 8'h05);
      @(posedge clock);
      chk_b(tx_trig_hit, 1'b1);
      $display("t_trig done");
   endtask
   // ==========================================
   // sequence and watchdog
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 5'h00;
      pwdata = 32'h0;
      n_errors = 0;
      comparisons = 0;
      cycles = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_regs();
      t_tx();
      t_rx_single();
      t_rx_fifo();
      t_trig();
      tally_and_finish();
   end
endmodule
